// ==== tpm_ctrl.v ====
// control logic of a three-phase voltage monitoring relay
// assumes per-phase in-tolerance flags from a front end, one 100 MHz clock
//
// Contract
// R1 - repeat phase capture every 60 seconds
// R2 - all phases good: outputs on after 3s
// R3 - phase out of tolerance: off after reaction
// R4 - missing phases switch the outputs off
// R5 - outputs stay off at least 1.5s
// R6 - trip latched on second indicator until cleared
// R7 - reaction selector: 10 ms plus 6 ms/step
// R8 - tolerance selector decodes to volt bands
// R9 - in-band fluctuations never trip the outputs
// R10 - bypass input suspends phase supervision
// R11 - indicators show readiness and relay states
// R12 - bypass keeps relays and signal output on
// R13 - brief excursion shows distinct indicator state
// R14 - one tick counter; switch-on delay restarts
// R15 - phase flags and bypass synchronised twice
`timescale 1ns/100ps
`include "tpm_map.vh"
module tpm_ctrl
#(
   parameter [31:0] TICK_CYCLES = `TPM_TICK_NS / `TPM_CLK_PERIOD_NS
)
(
   input  wire       ref_clk,
   input  wire       srst,
   input  wire       phase_one_input,
   input  wire       phase_two_input,
   input  wire       phase_three_input,
   input  wire       monitor_bypass_input,
   input  wire       supply_ok,
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   output reg        irq,
   output reg        first_contact_relay,
   output reg        second_contact_relay,
   output reg        transistor_signal_output,
   output reg        power_indicator,
   output reg        first_relay_led,
   output reg        second_relay_led,
   output reg        measure_capture,
   output reg  [7:0] tolerance_volts
);

   wire [3:0]               sync_q;
   wire                     all_ok;
   wire                     bypass_s;
   reg                      bypass_q;
   wire                     bypass_fall;
   wire                     bypass_edge;
   reg  [31:0]              div_cnt;
   wire                     ms_tick;
   reg  [15:0]              repeat_cnt;
   reg  [15:0]              tmr;
   reg  [15:0]              supply_cnt;
   reg  [15:0]              blink_cnt;
   reg                      blink;
   reg  [2:0]               state;
   reg                      outputs_on;
   reg                      trip_latched;
   reg                      transient;
   reg  [7:0]               cfg_word;
   reg  [`TPM_EV_WIDTH-1:0] event_st;
   reg  [`TPM_EV_WIDTH-1:0] event_mask;
   reg  [`TPM_EV_WIDTH-1:0] event_set;
   wire [3:0]               react_sel;
   wire [3:0]               tol_sel;
   wire [15:0]              react_ms;
   wire                     capture_due;
   wire                     on_done;
   wire                     react_done;
   wire                     min_off_done;
   wire                     supply_done;
   wire                     do_trip;
   wire                     do_recover;
   wire                     latch_clear;

   // phase flags and bypass brought onto ref_clk
   tpm_sync #(.WIDTH(4)) u_sync
   (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .async_in ({monitor_bypass_input, phase_three_input,
                  phase_two_input, phase_one_input}),
      .sync_out (sync_q)
   ); // R15

   // a missing or out-of-band phase both read as a low flag
   assign all_ok      = &sync_q[2:0]; // R4 R9
   assign bypass_s    = sync_q[3];
   assign bypass_fall = bypass_q & ~bypass_s;
   assign bypass_edge = bypass_q ^ bypass_s;

   // selector fields
   assign react_sel = cfg_word[`TPM_CFG_REACT_LSB +: 4];
   assign tol_sel   = cfg_word[`TPM_CFG_TOL_LSB +: 4];

   // reaction time in ms from the selector
   assign react_ms = `TPM_REACT_BASE_MS + {12'h000, react_sel} * `TPM_REACT_STEP_MS; // R7

   // timer end conditions, all on the shared ms tick
   assign ms_tick      = (div_cnt == TICK_CYCLES - 32'h0000_0001);
   assign capture_due  = ms_tick && (repeat_cnt == `TPM_REPEAT_MS - 16'h0001);
   assign on_done      = ms_tick && (tmr == `TPM_ON_DELAY_MS - 16'h0001);
   assign react_done   = ms_tick && (tmr >= react_ms - 16'h0001); // selector cut mid-wait
   assign min_off_done = ms_tick && (tmr == `TPM_MIN_OFF_MS - 16'h0001);
   assign supply_done  = ms_tick && (supply_cnt == `TPM_SUPPLY_OFF_MS - 16'h0001);

   // trip and short excursion decisions
   assign do_trip     = !bypass_s && (state == `TPM_ST_REACT) && !all_ok && react_done;
   assign do_recover  = !bypass_s && (state == `TPM_ST_REACT) && all_ok;
   assign latch_clear = bypass_fall || supply_done;

   // free-running 1 ms tick divider
   always @(posedge ref_clk)
   begin
      if (srst)
         div_cnt <= 32'h0000_0000;
      else if (ms_tick)
         div_cnt <= 32'h0000_0000;
      else
         div_cnt <= div_cnt + 32'h0000_0001;
   end // R14

   // 60 s measurement repeat, strobes the front end capture
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         repeat_cnt      <= 16'h0000;
         measure_capture <= 1'b0;
      end
      else
      begin
         measure_capture <= capture_due; // R1
         if (capture_due)
            repeat_cnt <= 16'h0000;
         else if (ms_tick)
            repeat_cnt <= repeat_cnt + 16'h0001;
      end
   end

   // supply-removed timer: 1 s of lost supply clears the latch
   always @(posedge ref_clk)
   begin
      if (srst)
         supply_cnt <= 16'h0000;
      else if (supply_ok || supply_done)
         supply_cnt <= 16'h0000;
      else if (ms_tick)
         supply_cnt <= supply_cnt + 16'h0001;
   end // R6

   // bypass history for edge detection
   always @(posedge ref_clk)
   begin
      if (srst)
         bypass_q <= 1'b0;
      else
         bypass_q <= bypass_s;
   end

   // main supervision state machine
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         state      <= `TPM_ST_DELAY;
         tmr        <= 16'h0000;
         outputs_on <= 1'b0;
      end
      else if (bypass_s)
      begin
         // supervision suspended, outputs held on
         state      <= `TPM_ST_BYPASS; // R10
         tmr        <= 16'h0000;
         outputs_on <= 1'b1; // R12
      end
      else
      begin
         case (state)
            `TPM_ST_DELAY:
            begin
               outputs_on <= 1'b0;
               if (!all_ok)
                  tmr <= 16'h0000; // R14
               else if (on_done)
               begin
                  state      <= `TPM_ST_ON;
                  tmr        <= 16'h0000;
                  outputs_on <= 1'b1; // R2
               end
               else if (ms_tick)
                  tmr <= tmr + 16'h0001;
            end
            `TPM_ST_ON:
            begin
               tmr <= 16'h0000;
               if (!all_ok)
                  state <= `TPM_ST_REACT;
            end
            `TPM_ST_REACT:
            begin
               if (do_recover)
               begin
                  state <= `TPM_ST_ON;
                  tmr   <= 16'h0000;
               end
               else if (do_trip)
               begin
                  state      <= `TPM_ST_OFFMIN;
                  tmr        <= 16'h0000;
                  outputs_on <= 1'b0; // R3 R4
               end
               else if (ms_tick)
                  tmr <= tmr + 16'h0001;
            end
            `TPM_ST_OFFMIN:
            begin
               outputs_on <= 1'b0; // R5
               if (min_off_done)
               begin
                  state <= `TPM_ST_DELAY;
                  tmr   <= 16'h0000;
               end
               else if (ms_tick)
                  tmr <= tmr + 16'h0001;
            end
            `TPM_ST_BYPASS:
            begin
               // bypass released: start again with the switch-on delay
               state      <= `TPM_ST_DELAY;
               tmr        <= 16'h0000;
               outputs_on <= 1'b0;
            end
            default:
            begin
               state      <= `TPM_ST_DELAY;
               tmr        <= 16'h0000;
               outputs_on <= 1'b0;
            end
         endcase
      end
   end

   // trip latch and short excursion flag, set wins over clear
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         trip_latched <= 1'b0;
         transient    <= 1'b0;
      end
      else
      begin
         if (do_trip)
            trip_latched <= 1'b1; // R6
         else if (latch_clear)
            trip_latched <= 1'b0; // R6
         if (do_recover)
            transient <= 1'b1; // R13
         else if (latch_clear)
            transient <= 1'b0;
      end
   end

   // blink clock for the excursion indication
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         blink_cnt <= 16'h0000;
         blink     <= 1'b0;
      end
      else if (ms_tick)
      begin
         if (blink_cnt == `TPM_BLINK_MS - 16'h0001)
         begin
            blink_cnt <= 16'h0000;
            blink     <= ~blink;
         end
         else
            blink_cnt <= blink_cnt + 16'h0001;
      end
   end

   // relays, signal output and indicators
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         first_contact_relay      <= 1'b0;
         second_contact_relay     <= 1'b0;
         transistor_signal_output <= 1'b0;
         power_indicator          <= 1'b0;
         first_relay_led          <= 1'b0;
         second_relay_led         <= 1'b0;
      end
      else
      begin
         first_contact_relay      <= outputs_on; // R2
         second_contact_relay     <= outputs_on;
         transistor_signal_output <= outputs_on;
         power_indicator          <= 1'b1; // R11
         first_relay_led          <= outputs_on; // R11
         // latched trip forces dark, excursion flashes
         if (trip_latched && !bypass_s)
            second_relay_led <= 1'b0; // R6
         else if (transient && !bypass_s)
            second_relay_led <= outputs_on & blink; // R13
         else
            second_relay_led <= outputs_on; // R11
      end
   end

   // tolerance band in volts for the front end comparators
   always @(posedge ref_clk)
   begin
      if (srst)
         tolerance_volts <= 8'h00;
      else
      begin
         case (tol_sel) // R8
            4'h1:    tolerance_volts <= 8'h0A;
            4'h2:    tolerance_volts <= 8'h13;
            4'h3:    tolerance_volts <= 8'h1D;
            4'h4:    tolerance_volts <= 8'h26;
            4'h5:    tolerance_volts <= 8'h30;
            4'h6:    tolerance_volts <= 8'h39;
            4'h7:    tolerance_volts <= 8'h43;
            4'h8:    tolerance_volts <= 8'h4C;
            4'h9:    tolerance_volts <= 8'h55;
            4'hA:    tolerance_volts <= 8'h5F;
            4'hB:    tolerance_volts <= 8'h69;
            4'hC:    tolerance_volts <= 8'h73;
            4'hD:    tolerance_volts <= 8'h7C;
            4'hE:    tolerance_volts <= 8'h85;
            4'hF:    tolerance_volts <= 8'h8F;
            default: tolerance_volts <= 8'h00; // position 0 undefined
         endcase
      end
   end

   // events gathered for the sticky status
   always @*
   begin
      event_set                    = {`TPM_EV_WIDTH{1'b0}};
      event_set[`TPM_EV_TRIP]      = do_trip;
      event_set[`TPM_EV_TRANSIENT] = do_recover;
      event_set[`TPM_EV_CAPTURE]   = capture_due;
      event_set[`TPM_EV_BYPASS]    = bypass_edge;
   end

   // config, sticky events (write one to clear), mask
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         cfg_word   <= `TPM_CFG_RESET;
         event_st   <= {`TPM_EV_WIDTH{1'b0}};
         event_mask <= {`TPM_EV_WIDTH{1'b0}};
      end
      else
      begin
         if (reg_wr && reg_addr == `TPM_ADDR_CONFIG)
            cfg_word <= reg_wdata; // R7 R8
         if (reg_wr && reg_addr == `TPM_ADDR_MASK)
            event_mask <= reg_wdata[`TPM_EV_WIDTH-1:0];
         if (reg_wr && reg_addr == `TPM_ADDR_EVENT)
            event_st <= (event_st & ~reg_wdata[`TPM_EV_WIDTH-1:0]) | event_set;
         else
            event_st <= event_st | event_set;
      end
   end

   // read data in the cycle after the strobe, irq as a level
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         reg_rdata <= 8'h00;
         irq       <= 1'b0;
      end
      else
      begin
         irq <= |(event_st & event_mask);
         if (reg_rd)
         begin
            case (reg_addr)
               `TPM_ADDR_CONFIG: reg_rdata <= cfg_word;
               `TPM_ADDR_STATE:  reg_rdata <= {transient, trip_latched, outputs_on,
                                               bypass_s, 1'b0, state};
               `TPM_ADDR_EVENT:  reg_rdata <= {4'h0, event_st};
               `TPM_ADDR_MASK:   reg_rdata <= {4'h0, event_mask};
               default:          reg_rdata <= 8'h00;
            endcase
         end
         else
            reg_rdata <= 8'h00;
      end
   end

endmodule

// ==== tpm_map.vh ====
// constants of the three-phase monitor control block
// assumes a 100 MHz ref_clk and a 1 ms internal tick
`ifndef TPM_MAP_VH
`define TPM_MAP_VH

// clock and tick timing
`define TPM_CLK_PERIOD_NS   10
`define TPM_TICK_NS         1000000

// delays counted in 1 ms ticks
`define TPM_REPEAT_MS       16'hEA60
`define TPM_ON_DELAY_MS     16'h0BB8
`define TPM_MIN_OFF_MS      16'h05DC
`define TPM_SUPPLY_OFF_MS   16'h03E8
`define TPM_BLINK_MS        16'h01F4
`define TPM_REACT_BASE_MS   16'h000A
`define TPM_REACT_STEP_MS   16'h0006

// register byte addresses
`define TPM_ADDR_CONFIG     4'h0
`define TPM_ADDR_STATE      4'h4
`define TPM_ADDR_EVENT      4'h8
`define TPM_ADDR_MASK       4'hC

// config fields and reset value (reaction 1, tolerance 4)
`define TPM_CFG_REACT_LSB   0
`define TPM_CFG_TOL_LSB     4
`define TPM_CFG_RESET       8'h41

// event bits
`define TPM_EV_TRIP         0
`define TPM_EV_TRANSIENT    1
`define TPM_EV_CAPTURE      2
`define TPM_EV_BYPASS       3
`define TPM_EV_WIDTH        4

// control states
`define TPM_ST_DELAY        3'h0
`define TPM_ST_ON           3'h1
`define TPM_ST_REACT        3'h2
`define TPM_ST_OFFMIN       3'h3
`define TPM_ST_BYPASS       3'h4

`endif

// ==== tpm_sync.v ====
// two-stage synchroniser, one flop pair per bit
// assumes every input bit is a level; only the second stage is read
`timescale 1ns/100ps
module tpm_sync
#(
   parameter WIDTH = 4
)
(
   input  wire             ref_clk,
   input  wire             srst,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         reg meta;
         reg stable;
         // first stage feeds the second only
         always @(posedge ref_clk)
         begin
            if (srst)
            begin
               meta   <= 1'b0;
               stable <= 1'b0;
            end
            else
            begin
               meta   <= async_in[i];
               stable <= meta;
            end
         end
         assign sync_out[i] = stable;
      end
   endgenerate

endmodule

// ==== tpm_front_model.sv ====
// front end model: phase flags and bypass wiring
// assumes the bench sets the commands just after a rising edge
`timescale 1ns/100ps
module tpm_front_model
(
   input  logic [2:0] good_cmd,
   input  logic       bypass_cmd,
   output logic       phase_one_input,
   output logic       phase_two_input,
   output logic       phase_three_input,
   output logic       monitor_bypass_input
);
   // a missing phase reads as a low in-tolerance flag
   assign {phase_three_input, phase_two_input, phase_one_input} = good_cmd;
   // the bypass switch deselects monitoring while closed
   assign monitor_bypass_input = bypass_cmd;
endmodule

// ==== tpm_ctrl_checker.sv ====
// port assertions for the three-phase monitor control
// assumes binding to tpm_ctrl, one clock, sync reset srst
`timescale 1ns/100ps
module tpm_ctrl_checker
#(
   parameter [31:0] TICK_CYCLES = 10
)
(
   input logic       ref_clk,
   input logic       srst,
   input logic       phase_one_input,
   input logic       phase_two_input,
   input logic       phase_three_input,
   input logic       monitor_bypass_input,
   input logic       reg_rd,
   input logic [7:0] reg_rdata,
   input logic       irq,
   input logic       first_contact_relay,
   input logic       second_contact_relay,
   input logic       transistor_signal_output,
   input logic       power_indicator,
   input logic       first_relay_led,
   input logic       second_relay_led
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   logic        good;
   logic [31:0] good_cnt;
   logic [31:0] bad_cnt;
   logic [31:0] off_cnt;
   assign good = phase_one_input & phase_two_input & phase_three_input;
   // run lengths of good phases, bad phases and relay off
   always @(posedge ref_clk)
   begin
      good_cnt <= (srst | !good) ? 32'h0 : good_cnt + 32'h1;
      bad_cnt  <= (srst | good | monitor_bypass_input) ? 32'h0 : bad_cnt + 32'h1;
      off_cnt  <= (srst | first_contact_relay) ? 32'h0 : off_cnt + 32'h1;
   end
   chk_outputs_together: assert property (
      first_contact_relay == second_contact_relay
      && first_contact_relay == transistor_signal_output) else $error("outputs differ");
   chk_power_lit: assert property (
      !$past(srst) |-> power_indicator) else $error("power indicator dark");
   chk_led_tracks: assert property (
      $rose(first_contact_relay) |-> ##[0:1] first_relay_led) else $error("relay led late");
   chk_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside answer");
   chk_bypass_on: assert property (
      monitor_bypass_input [*5] |-> first_contact_relay) else $error("bypass left relay off");
   chk_trip_dark: assert property (
      $fell(first_contact_relay) && !$past(monitor_bypass_input, 6)
      |-> ##[0:2] !second_relay_led) else $error("trip led not dark");
   chk_min_off: assert property (
      $rose(first_contact_relay) && !monitor_bypass_input
      |-> off_cnt >= 1499 * TICK_CYCLES) else $error("off time too short");
   chk_on_delay: assert property (
      $rose(first_contact_relay) && !monitor_bypass_input
      |-> good_cnt >= 2998 * TICK_CYCLES) else $error("switch-on too early");
   chk_bad_trips: assert property (
      bad_cnt > 101 * TICK_CYCLES + 8 |-> !first_contact_relay) else $error("no trip");
   chk_in_band: assert property (
      (first_contact_relay && good && !monitor_bypass_input) [*6]
      |=> first_contact_relay) else $error("trip while in band");
   // main scenarios
   cov_on: cover property ($rose(first_contact_relay));
   cov_trip: cover property ($fell(first_contact_relay));
   cov_irq: cover property ($rose(irq));
endmodule
bind tpm_ctrl tpm_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);

// ==== test_three_phase_monitor_control.sv ====
// bench of the monitor control block with a front end model
// assumes TICK_CYCLES of 10, so one tick is ten clocks
`timescale 1ns/100ps
`include "tpm_map.vh"
module test_three_phase_monitor_control;
   localparam T = 10;
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic [2:0]  good_cmd = 3'h7;
   logic        bypass_cmd = 1'b0;
   logic        supply_ok = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rd_q = 1'b0;
   logic [31:0] rnd = 32'h84D019A2;
   logic [7:0]  exp_q [$];
   logic [7:0]  tol [16] = '{8'h00, 8'h0A, 8'h13, 8'h1D, 8'h26, 8'h30, 8'h39, 8'h43,
                             8'h4C, 8'h55, 8'h5F, 8'h69, 8'h73, 8'h7C, 8'h85, 8'h8F};
   int          fail_count = 0;
   int          compares = 0;
   int          cyc = 0;
   int          t0, n, rs;
   wire         phase_one_input, phase_two_input, phase_three_input, monitor_bypass_input;
   wire         irq, first_contact_relay, second_contact_relay, transistor_signal_output;
   wire         power_indicator, first_relay_led, second_relay_led, measure_capture;
   wire [7:0]   reg_rdata, tolerance_volts;
   tpm_front_model model_u (.*);
   tpm_ctrl #(.TICK_CYCLES(T)) dut_u (.*);
   always #5 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic test_done();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   // one write, or one read noting its expected data
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) exp_q.push_back(d);
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
   task automatic set_in(input logic [2:0] g, input logic b);
      @(posedge ref_clk);
      good_cmd <= g;
      bypass_cmd <= b;
      #1;
   endtask
   task automatic wait_rly(input logic v, input int lim);
      n = 0;
      while (first_contact_relay !== v && n < lim)
      begin
         tick(1);
         n++;
      end
      if (n >= lim)
      begin
         fail_count++;
         $display("[ERR] relay expected %h seen %h", v, first_contact_relay);
         test_done();
      end
   endtask
   // answer watcher: read data the cycle after the strobe
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      rd_q <= reg_rd;
      if (rd_q) chk("reg_rdata", reg_rdata, exp_q.pop_front());
      // the run is shorter than one repeat period, so no capture strobe may appear
      if (measure_capture) chk("capture_early", 1'b1, 1'b0);
   end
   // main sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      t0 = cyc;
      tick(2);
      chk("power", power_indicator, 1'b1);
      chk("tol_reset", tolerance_volts, 8'h26);
      bus(0, `TPM_ADDR_CONFIG, 8'h41);
      bus(0, `TPM_ADDR_MASK, 8'h00);
      bus(0, 4'h2, 8'h00);
      for (int i = 0; i < 16; i++)
      begin
         rnd = xs(rnd);
         bus(1, `TPM_ADDR_CONFIG, {i[3:0], rnd[3:0]});
         tick(2);
         chk("tol_volts", tolerance_volts, tol[i]);
      end
      rs = rnd[3:0];
      bus(1, `TPM_ADDR_CONFIG, {4'h4, rnd[3:0]});
      bus(1, `TPM_ADDR_MASK, 8'h0F);
      wait_rly(1'b1, 31000);
      chk("on_delay", (cyc - t0) inside {[2998*T:3001*T]}, 1'b1);
      chk("outs", {second_contact_relay, transistor_signal_output, first_relay_led}, 3'h7);
      set_in(3'h5, 1'b0);
      t0 = cyc;
      wait_rly(1'b0, 1100);
      chk("react", (cyc - t0) inside {[(9+6*rs)*T:(10+6*rs)*T+8]}, 1'b1);
      t0 = cyc;
      set_in(3'h7, 1'b0);
      bus(0, `TPM_ADDR_STATE, 8'h43);
      bus(0, `TPM_ADDR_EVENT, 8'h01);
      chk("trip_led", second_relay_led, 1'b0);
      chk("irq_set", irq, 1'b1);
      bus(1, `TPM_ADDR_EVENT, 8'h01);
      tick(3);
      chk("irq_clr", irq, 1'b0);
      wait_rly(1'b1, 46000);
      chk("min_off", (cyc - t0) inside {[4497*T:4501*T]}, 1'b1);
      chk("latched", {second_relay_led, first_relay_led}, 2'h1);
      set_in(3'h6, 1'b0);
      tick(3*T);
      set_in(3'h7, 1'b0);
      tick(30*T);
      chk("brief", first_contact_relay, 1'b1);
      bus(0, `TPM_ADDR_EVENT, 8'h02);
      bus(0, `TPM_ADDR_STATE, 8'hE1);
      // supply removed for just over 1 s clears latch and excursion flag
      supply_ok <= 1'b0;
      tick(1001*T);
      chk("led_clear", second_relay_led, 1'b1);
      @(posedge ref_clk);
      supply_ok <= 1'b1;
      bus(0, `TPM_ADDR_STATE, 8'h21);
      set_in(3'h7, 1'b1);
      tick(5);
      set_in(3'h0, 1'b1);
      tick(200*T);
      chk("bypass_on", {first_contact_relay, transistor_signal_output}, 2'h3);
      bus(0, `TPM_ADDR_STATE, 8'h34);
      bus(0, `TPM_ADDR_EVENT, 8'h0A);
      set_in(3'h0, 1'b0);
      tick(6);
      chk("bypass_off", first_contact_relay, 1'b0);
      bus(0, `TPM_ADDR_STATE, 8'h00);
      bus(1, `TPM_ADDR_STATE, 8'hFF);
      bus(0, `TPM_ADDR_STATE, 8'h00);
      // bypass from relay off: on within sync plus two flops
      set_in(3'h0, 1'b1);
      tick(5);
      chk("bypass_rly", first_contact_relay, 1'b1);
      tick(110*T);
      test_done();
   end
endmodule
